// ===== cab_regs.vh
// Purpose: Shared constants for the arithmetic and branch execution core
// Assumes: Instruction word layout and opcode values are local to this core
// Notes:   Included by cab_alu.v and cab_exec.v
`ifndef CAB_REGS_VH
`define CAB_REGS_VH
////////////////////////////////////////////////////////////////////////////
// Register-form opcodes, word bit 15 low, opcode in bits 14:10
`define CAB_OP_SUM 5'h00
`define CAB_OP_SUM_CARRY 5'h01
`define CAB_OP_DIFF 5'h02
`define CAB_OP_DIFF_BORROW 5'h03
`define CAB_OP_AND 5'h04
`define CAB_OP_OR 5'h05
`define CAB_OP_XOR 5'h06
`define CAB_OP_INVERT 5'h07
`define CAB_OP_SIGN_FLIP 5'h08
`define CAB_OP_PLUS_ONE 5'h09
`define CAB_OP_MINUS_ONE 5'h0a
`define CAB_OP_UPROD 5'h0b
`define CAB_OP_SPROD 5'h0c
`define CAB_OP_MPROD 5'h0d
`define CAB_OP_FUPROD 5'h0e
`define CAB_OP_FSPROD 5'h0f
`define CAB_OP_FMPROD 5'h10
`define CAB_OP_CMP 5'h11
`define CAB_OP_CMP_CARRY 5'h12
`define CAB_OP_CMP_SKIP 5'h13
`define CAB_OP_SKIP_RBIT_LO 5'h14
`define CAB_OP_SKIP_RBIT_HI 5'h15
`define CAB_OP_SKIP_IO_LO 5'h16
`define CAB_OP_SKIP_IO_HI 5'h17
`define CAB_OP_WORD_ADD 5'h18
`define CAB_OP_WORD_SUB 5'h19
`define CAB_OP_PTR_JUMP 5'h1a
`define CAB_OP_PTR_CALL 5'h1b
`define CAB_OP_ABS_JUMP 5'h1c
`define CAB_OP_ABS_CALL 5'h1d
`define CAB_OP_SUB_EXIT 5'h1e
`define CAB_OP_INT_EXIT 5'h1f
// Immediate-form opcodes, word bit 15 high, opcode in bits 14:12
`define CAB_IOP_DIFF_K 3'h0
`define CAB_IOP_DIFF_K_BORROW 3'h1
`define CAB_IOP_AND_K 3'h2
`define CAB_IOP_OR_K 3'h3
`define CAB_IOP_CMP_K 3'h4
`define CAB_IOP_ALL_ONES 3'h5
`define CAB_IOP_REL_JUMP 3'h6
`define CAB_IOP_REL_CALL 3'h7
////////////////////////////////////////////////////////////////////////////
// Status bits and update masks
`define CAB_C 0
`define CAB_I 7
`define CAB_FL_ARITH 8'h2f
`define CAB_FL_LOGIC 8'h0e
`define CAB_FL_INV 8'h0f
`define CAB_FL_WORD 8'h1f
`define CAB_FL_PROD 8'h03
////////////////////////////////////////////////////////////////////////////
// Software port map and reset values
`define CAB_SW_SREG 6'h20
`define CAB_SW_PCL 6'h21
`define CAB_SW_PCH 6'h22
`define CAB_SW_STAT 6'h23
`define CAB_SW_CTRL 6'h24
`define CAB_SREG_RST 8'h00
`define CAB_PC_RST 16'h0000
`define CAB_CTRL_RST 1'b0
////////////////////////////////////////////////////////////////////////////
// Cycle counts per instruction
`define CAB_CYC_WORD 3'd2
`define CAB_CYC_PROD 3'd2
`define CAB_CYC_JUMP 3'd2
`define CAB_CYC_ABS_JUMP 3'd3
`define CAB_CYC_CALL 3'd3
`define CAB_CYC_ABS_CALL 3'd4
`define CAB_CYC_EXIT 3'd4
`endif

// ===== cab_alu.v
// Purpose: Combinational result and status computation for the core
// Assumes: Opcodes from cab_regs.vh; non-arithmetic opcodes change nothing
// Notes:   Word ops take the immediate from the low six bits of b
`timescale 1ns/1ps
`default_nettype none
`include "cab_regs.vh"
module cab_alu (
   // Operation and operands
   input wire [4:0] op,
   input wire [7:0] a,
   input wire [7:0] b,
   input wire [15:0] w,
   input wire [7:0] sreg,
   // Result and status
   output reg [15:0] res,
   output reg [7:0] sreg_next
);
   localparam K_ADD = 3'd0, K_SUB = 3'd1, K_LOG = 3'd2;
   localparam K_WORD = 3'd3, K_PROD = 3'd4;
   reg [2:0] kind;
   reg [7:0] aa, bb, r, m;
   reg ci, c, h, v, n, z, sa, sb, fr, wide;
   reg [8:0] s9;
   reg [16:0] w17;
   reg signed [17:0] p;
   always @* begin
      kind = K_LOG;
      aa = a;
      bb = b;
      ci = 1'b0;
      m = 8'h00;
      r = 8'h00;
      c = 1'b0;
      h = 1'b0;
      v = 1'b0;
      sa = 1'b0;
      sb = 1'b0;
      fr = 1'b0;
      w17 = 17'h00000;
      p = 18'sh00000;
      res = 16'h0000;
      case (op)
         `CAB_OP_SUM, `CAB_OP_SUM_CARRY: begin
            kind = K_ADD;
            ci = (op == `CAB_OP_SUM_CARRY) & sreg[`CAB_C];
            m = `CAB_FL_ARITH;
         end
         `CAB_OP_DIFF, `CAB_OP_DIFF_BORROW, `CAB_OP_CMP,
         `CAB_OP_CMP_CARRY: begin
            kind = K_SUB;
            ci = ((op == `CAB_OP_DIFF_BORROW) |
                  (op == `CAB_OP_CMP_CARRY)) & sreg[`CAB_C];
            m = `CAB_FL_ARITH;
         end
         `CAB_OP_AND: begin
            r = a & b;
            m = `CAB_FL_LOGIC;
         end
         `CAB_OP_OR: begin
            r = a | b;
            m = `CAB_FL_LOGIC;
         end
         `CAB_OP_XOR: begin
            r = a ^ b;
            m = `CAB_FL_LOGIC;
         end
         `CAB_OP_INVERT: begin
            r = 8'hff - a;
            c = 1'b1;
            m = `CAB_FL_INV;
         end
         `CAB_OP_SIGN_FLIP: begin
            kind = K_SUB;
            aa = 8'h00;
            bb = a;
            m = `CAB_FL_ARITH;
         end
         `CAB_OP_PLUS_ONE, `CAB_OP_MINUS_ONE: begin
            kind = (op == `CAB_OP_PLUS_ONE) ? K_ADD : K_SUB;
            bb = 8'h01;
            m = `CAB_FL_LOGIC;
         end
         `CAB_OP_WORD_ADD, `CAB_OP_WORD_SUB: begin
            kind = K_WORD;
            m = `CAB_FL_WORD;
         end
         `CAB_OP_UPROD, `CAB_OP_SPROD, `CAB_OP_MPROD, `CAB_OP_FUPROD,
         `CAB_OP_FSPROD, `CAB_OP_FMPROD: begin
            kind = K_PROD;
            sa = (op == `CAB_OP_SPROD) | (op == `CAB_OP_MPROD) |
                 (op == `CAB_OP_FSPROD) | (op == `CAB_OP_FMPROD);
            sb = (op == `CAB_OP_SPROD) | (op == `CAB_OP_FSPROD);
            fr = (op == `CAB_OP_FUPROD) | (op == `CAB_OP_FSPROD) |
                 (op == `CAB_OP_FMPROD);
            m = `CAB_FL_PROD;
         end
         default: m = 8'h00;
      endcase
      if (kind == K_SUB)
         s9 = {1'b0, aa} - {1'b0, bb} - {8'h00, ci};
      else
         s9 = {1'b0, aa} + {1'b0, bb} + {8'h00, ci};
      case (kind)
         K_ADD: begin
            r = s9[7:0];
            c = s9[8];
            h = aa[3] & bb[3] | bb[3] & ~r[3] | ~r[3] & aa[3];
            v = aa[7] & bb[7] & ~r[7] | ~aa[7] & ~bb[7] & r[7];
         end
         K_SUB: begin
            r = s9[7:0];
            c = ~aa[7] & bb[7] | bb[7] & r[7] | r[7] & ~aa[7];
            h = ~aa[3] & bb[3] | bb[3] & r[3] | r[3] & ~aa[3];
            v = aa[7] & ~bb[7] & ~r[7] | ~aa[7] & bb[7] & r[7];
         end
         K_WORD: begin
            if (op == `CAB_OP_WORD_ADD) begin
               w17 = {1'b0, w} + {11'h000, bb[5:0]};
               v = ~w[15] & w17[15];
               c = w[15] & ~w17[15];
            end else begin
               w17 = {1'b0, w} - {11'h000, bb[5:0]};
               v = w[15] & ~w17[15];
               c = ~w[15] & w17[15];
            end
            res = w17[15:0];
         end
         K_PROD: begin
            p = $signed({sa & aa[7], aa}) * $signed({sb & bb[7], bb});
            c = p[15];
            res = fr ? {p[14:0], 1'b0} : p[15:0];
         end
         default: res = 16'h0000;
      endcase
      wide = (kind == K_WORD) | (kind == K_PROD);
      if (!wide)
         res = {8'h00, r};
      n = wide ? res[15] : r[7];
      z = wide ? (res == 16'h0000) : (r == 8'h00);
      sreg_next = (sreg & ~m) | ({2'b00, h, n ^ v, v, n, z, c} & m);
   end
endmodule // cab_alu
`default_nettype wire

// ===== cab_exec.v
// Purpose: Execution core for arithmetic, logic, jump, call and skip ops
// Assumes: Program memory answers pm_addr in the same cycle; io_rdata too
// Notes:   Core starts instructions only while the run bit of the control register is set
`timescale 1ns/1ps
`default_nettype none
`include "cab_regs.vh"
// Summary of operation
// - Sum with carry adds the carry flag; plain sum does not; ZCNVH, 1 cycle.
// - Differences, register or constant, borrow forms subtract carry; ZCNVH.
// - Word add/subtract immediate on a register pair; ZCNVS; two cycles.
// - AND, OR register or constant forms, XOR register form only; only ZNV; one cycle.
// - Invert gives 0xFF minus value; sign flip 0x00 minus, adds H.
// - Plus one and minus one update only Z, N, V; carry kept.
// - Test is AND with itself, clear is XOR; all-ones load no flags.
// - Products of two registers go to pair one:zero; Z, C; two cycles.
// - Fractional products shift left one before writing pair one:zero.
// - Relative jump PC+k+1, pointer jump Z, two cycles; absolute three.
// - Calls three or four cycles; exits four; interrupt exit sets I.
// - Compare-skip-equal skips the next instruction when registers match.
// - Compares compute the difference, write nothing, update ZNVCH.
// - Skip on selected register bit low or high; no flags.
// - Skip on selected I/O register bit low or high; no flags.
// - I/O bit tests reach only I/O addresses 0x00 to 0x1F.
module cab_exec #(
   parameter STACK_DEPTH = 16,
   parameter SP_W = 4
) (
   // Clock and reset
   input wire clk,
   input wire arst_n,
   // Program memory
   output wire [15:0] pm_addr,
   input wire [15:0] pm_data,
   // I/O space bit test
   output wire [4:0] io_addr,
   output wire io_rd,
   input wire [7:0] io_rdata,
   // Software register port
   input wire [5:0] sw_addr,
   input wire [7:0] sw_wdata,
   input wire sw_wr,
   input wire sw_rd,
   output reg [7:0] sw_rdata,
   // Status
   output wire busy
);
   localparam S_EXEC = 4'b0001;
   localparam S_FETCH2 = 4'b0010;
   localparam S_SKIP = 4'b0100;
   localparam S_STALL = 4'b1000;

   reg [7:0] gpr [0:31];
   reg [15:0] stack_mem [0:STACK_DEPTH-1];
   reg [3:0] state_reg, state_next;
   reg [15:0] pc_reg, pc_next;
   reg [SP_W-1:0] sp_reg, sp_next;
   reg [7:0] sreg_reg, sreg_next;
   reg [2:0] cnt_reg, cnt_next;
   reg call_reg, call_next;
   reg run_reg;
   reg wa_en, wb_en, push_en, cond;
   reg [4:0] wa_addr, wb_addr;
   reg [7:0] wa_data, wb_data;

   ////////////////////////////////////////////////////////////////////////
   // Decode of the word on the program memory bus
   function is_two_word;
      input [15:0] word;
      begin
         is_two_word = ~word[15] &
                       ((word[14:10] == `CAB_OP_ABS_JUMP) |
                        (word[14:10] == `CAB_OP_ABS_CALL));
      end
   endfunction

   wire [15:0] ir = pm_data;
   wire imm = ir[15];
   wire [4:0] op = ir[14:10];
   wire [2:0] iop = ir[14:12];
   wire [4:0] rd = imm ? {1'b1, ir[11:8]} : ir[9:5];
   wire [4:0] pair_lo = {2'b11, ir[9:8], 1'b0};
   wire [4:0] pair_hi = {2'b11, ir[9:8], 1'b1};
   wire is_word = ~imm &
                  ((op == `CAB_OP_WORD_ADD) | (op == `CAB_OP_WORD_SUB));
   wire [15:0] pc_inc = pc_reg + 16'h0001;
   wire [15:0] pc_rel = pc_reg + {{4{ir[11]}}, ir[11:0]} + 16'h0001;
   wire [15:0] z_ptr = {gpr[31], gpr[30]};
   wire [SP_W-1:0] sp_pop = sp_reg - {{(SP_W-1){1'b0}}, 1'b1};
   wire halted = ~run_reg & (state_reg == S_EXEC);
   wire exec_now = run_reg & (state_reg == S_EXEC);
   reg [4:0] alu_op;
   wire [15:0] alu_res;
   wire [7:0] alu_sreg;

   always @* begin
      alu_op = op;
      if (imm) begin
         case (iop)
            `CAB_IOP_DIFF_K: alu_op = `CAB_OP_DIFF;
            `CAB_IOP_DIFF_K_BORROW: alu_op = `CAB_OP_DIFF_BORROW;
            `CAB_IOP_AND_K: alu_op = `CAB_OP_AND;
            `CAB_IOP_OR_K: alu_op = `CAB_OP_OR;
            `CAB_IOP_CMP_K: alu_op = `CAB_OP_CMP;
            default: alu_op = `CAB_OP_CMP_SKIP;
         endcase
      end
   end

   cab_alu u_alu (
      .op(alu_op),
      .a(gpr[rd]),
      .b((imm | is_word) ? ir[7:0] : gpr[ir[4:0]]),
      .w({gpr[pair_hi], gpr[pair_lo]}),
      .sreg(sreg_reg),
      .res(alu_res),
      .sreg_next(alu_sreg)
   );

   // Bit tests only carry a five-bit I/O address
   assign io_addr = ir[9:5];
   assign io_rd = exec_now & ~imm & ((op == `CAB_OP_SKIP_IO_LO) |
                                    (op == `CAB_OP_SKIP_IO_HI));
   assign pm_addr = pc_reg;
   assign busy = ~(state_reg == S_EXEC);

   ////////////////////////////////////////////////////////////////////////
   // Sequencing
   always @* begin
      state_next = state_reg;
      pc_next = pc_reg;
      sp_next = sp_reg;
      sreg_next = sreg_reg;
      cnt_next = cnt_reg;
      call_next = call_reg;
      wa_en = 1'b0;
      wa_addr = rd;
      wa_data = alu_res[7:0];
      wb_en = 1'b0;
      wb_addr = 5'h01;
      wb_data = alu_res[15:8];
      push_en = 1'b0;
      cond = 1'b0;
      case (state_reg)
         S_EXEC: if (run_reg) begin
            pc_next = pc_inc;
            if (imm) begin
               case (iop)
                  `CAB_IOP_CMP_K: sreg_next = alu_sreg;
                  `CAB_IOP_ALL_ONES: begin
                     wa_en = 1'b1;
                     wa_data = 8'hff;
                  end
                  `CAB_IOP_REL_JUMP: begin
                     pc_next = pc_rel;
                     state_next = S_STALL;
                     cnt_next = `CAB_CYC_JUMP - 3'd2;
                  end
                  `CAB_IOP_REL_CALL: begin
                     push_en = 1'b1;
                     pc_next = pc_rel;
                     sp_next = sp_reg + {{(SP_W-1){1'b0}}, 1'b1};
                     state_next = S_STALL;
                     cnt_next = `CAB_CYC_CALL - 3'd2;
                  end
                  default: begin
                     wa_en = 1'b1;
                     sreg_next = alu_sreg;
                  end
               endcase
            end else if (is_two_word(ir)) begin
               call_next = (op == `CAB_OP_ABS_CALL);
               state_next = S_FETCH2;
            end else begin
               case (op)
                  `CAB_OP_CMP, `CAB_OP_CMP_CARRY:
                     sreg_next = alu_sreg;
                  `CAB_OP_UPROD, `CAB_OP_SPROD, `CAB_OP_MPROD,
                  `CAB_OP_FUPROD, `CAB_OP_FSPROD, `CAB_OP_FMPROD: begin
                     wa_en = 1'b1;
                     wa_addr = 5'h00;
                     wb_en = 1'b1;
                     sreg_next = alu_sreg;
                     state_next = S_STALL;
                     cnt_next = `CAB_CYC_PROD - 3'd2;
                  end
                  `CAB_OP_WORD_ADD, `CAB_OP_WORD_SUB: begin
                     wa_en = 1'b1;
                     wa_addr = pair_lo;
                     wb_en = 1'b1;
                     wb_addr = pair_hi;
                     sreg_next = alu_sreg;
                     state_next = S_STALL;
                     cnt_next = `CAB_CYC_WORD - 3'd2;
                  end
                  `CAB_OP_PTR_JUMP: begin
                     pc_next = z_ptr;
                     state_next = S_STALL;
                     cnt_next = `CAB_CYC_JUMP - 3'd2;
                  end
                  `CAB_OP_PTR_CALL: begin
                     push_en = 1'b1;
                     pc_next = z_ptr;
                     sp_next = sp_reg + {{(SP_W-1){1'b0}}, 1'b1};
                     state_next = S_STALL;
                     cnt_next = `CAB_CYC_CALL - 3'd2;
                  end
                  `CAB_OP_SUB_EXIT, `CAB_OP_INT_EXIT: begin
                     pc_next = stack_mem[sp_pop];
                     sp_next = sp_pop;
                     if (op == `CAB_OP_INT_EXIT)
                        sreg_next[`CAB_I] = 1'b1;
                     state_next = S_STALL;
                     cnt_next = `CAB_CYC_EXIT - 3'd2;
                  end
                  `CAB_OP_CMP_SKIP, `CAB_OP_SKIP_RBIT_LO,
                  `CAB_OP_SKIP_RBIT_HI, `CAB_OP_SKIP_IO_LO,
                  `CAB_OP_SKIP_IO_HI: begin
                     case (op)
                        `CAB_OP_CMP_SKIP:
                           cond = (gpr[rd] == gpr[ir[4:0]]);
                        `CAB_OP_SKIP_RBIT_LO:
                           cond = ~gpr[rd][ir[2:0]];
                        `CAB_OP_SKIP_RBIT_HI:
                           cond = gpr[rd][ir[2:0]];
                        `CAB_OP_SKIP_IO_LO:
                           cond = ~io_rdata[ir[2:0]];
                        default:
                           cond = io_rdata[ir[2:0]];
                     endcase
                     if (cond)
                        state_next = S_SKIP;
                  end
                  default: begin
                     wa_en = 1'b1;
                     sreg_next = alu_sreg;
                  end
               endcase
            end
         end
         S_FETCH2: begin
            pc_next = ir;
            state_next = S_STALL;
            if (call_reg) begin
               push_en = 1'b1;
               sp_next = sp_reg + {{(SP_W-1){1'b0}}, 1'b1};
               cnt_next = `CAB_CYC_ABS_CALL - 3'd3;
            end else begin
               cnt_next = `CAB_CYC_ABS_JUMP - 3'd3;
            end
         end
         S_SKIP: begin
            // The word under the skip decides one or two words to pass
            if (is_two_word(ir)) begin
               pc_next = pc_reg + 16'h0002;
               state_next = S_STALL;
               cnt_next = 3'd0;
            end else begin
               pc_next = pc_inc;
               state_next = S_EXEC;
            end
         end
         S_STALL: begin
            if (cnt_reg == 3'd0)
               state_next = S_EXEC;
            else
               cnt_next = cnt_reg - 3'd1;
         end
         default: state_next = S_EXEC;
      endcase
      // Architectural state is only writable while the core is parked
      if (sw_wr && halted) begin
         case (sw_addr)
            `CAB_SW_SREG: sreg_next = sw_wdata;
            `CAB_SW_PCL: pc_next = {pc_reg[15:8], sw_wdata};
            `CAB_SW_PCH: pc_next = {sw_wdata, pc_reg[7:0]};
            default: sreg_next = sreg_next;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Storage
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state_reg <= S_EXEC;
         pc_reg <= `CAB_PC_RST;
         sp_reg <= {SP_W{1'b0}};
         sreg_reg <= `CAB_SREG_RST;
         cnt_reg <= 3'd0;
         call_reg <= 1'b0;
         run_reg <= `CAB_CTRL_RST;
         sw_rdata <= 8'h00;
      end else begin
         state_reg <= state_next;
         pc_reg <= pc_next;
         sp_reg <= sp_next;
         sreg_reg <= sreg_next;
         cnt_reg <= cnt_next;
         call_reg <= call_next;
         if (sw_wr && (sw_addr == `CAB_SW_CTRL))
            run_reg <= sw_wdata[0];
         if (sw_rd) begin
            if (!sw_addr[5])
               sw_rdata <= gpr[sw_addr[4:0]];
            else begin
               case (sw_addr)
                  `CAB_SW_SREG: sw_rdata <= sreg_reg;
                  `CAB_SW_PCL: sw_rdata <= pc_reg[7:0];
                  `CAB_SW_PCH: sw_rdata <= pc_reg[15:8];
                  `CAB_SW_STAT: sw_rdata <= {4'h0, state_reg};
                  `CAB_SW_CTRL: sw_rdata <= {7'h00, run_reg};
                  default: sw_rdata <= 8'h00;
               endcase
            end
         end
      end
   end

   // Register file and stack carry no reset; software loads the register file
   always @(posedge clk) begin
      if (sw_wr && halted && !sw_addr[5])
         gpr[sw_addr[4:0]] <= sw_wdata;
      if (wa_en)
         gpr[wa_addr] <= wa_data;
      if (wb_en)
         gpr[wb_addr] <= wb_data;
      if (push_en)
         stack_mem[sp_reg] <= pc_inc;
   end
endmodule // cab_exec
`default_nettype wire

// ===== cab_exec_properties.sv
// Purpose: Port-level timing and target checks for cab_exec
// Assumes: Run bit is mirrored from software writes to the control address
// Notes:   Taken skips are not timed; the skipped width is not visible here
`timescale 1ns/1ps
`default_nettype none
`include "cab_regs.vh"
module cab_exec_props #(
   parameter STACK_DEPTH = 16,
   parameter SP_W = 4
) (
   // Core
   input wire clk,
   input wire arst_n,
   input wire busy,
   // Program memory and I/O
   input wire [15:0] pm_addr,
   input wire [15:0] pm_data,
   input wire [4:0] io_addr,
   input wire io_rd,
   input wire [7:0] io_rdata,
   // Software port
   input wire [5:0] sw_addr,
   input wire [7:0] sw_wdata,
   input wire sw_wr,
   input wire sw_rd,
   input wire [7:0] sw_rdata
);
////////////////////////////////////////////////////////////////////////////
   logic run_reg;
   wire ex = run_reg && !busy;
   wire rf = !pm_data[15];
   wire [4:0] op = pm_data[14:10];
   wire [15:0] rel_t = pm_addr + {{4{pm_data[11]}}, pm_data[11:0]} + 16'h0001;
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         run_reg <= 1'b0;
      end else if (sw_wr && sw_addr == `CAB_SW_CTRL) begin
         run_reg <= sw_wdata[0];
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   io_addr_map_a: assert property (io_addr == pm_data[9:5])
      else $error("io_addr does not follow the instruction field");
   io_rd_cause_a: assert property (io_rd |-> !busy && rf &&
      (op == `CAB_OP_SKIP_IO_LO || op == `CAB_OP_SKIP_IO_HI))
      else $error("io_rd outside an I/O bit skip");
   one_cycle_ops_a: assert property (ex && ((rf && (op <= `CAB_OP_MINUS_ONE ||
      op == `CAB_OP_CMP || op == `CAB_OP_CMP_CARRY)) ||
      (pm_data[15] && pm_data[14:12] <= `CAB_IOP_ALL_ONES))
      |=> !busy && pm_addr == $past(pm_addr) + 16'h0001)
      else $error("single cycle op did not advance by one");
   two_cycle_ops_a: assert property (ex && rf &&
      ((op >= `CAB_OP_UPROD && op <= `CAB_OP_FMPROD) ||
      op == `CAB_OP_WORD_ADD || op == `CAB_OP_WORD_SUB)
      |=> busy ##1 !busy && pm_addr == $past(pm_addr, 2) + 16'h0001)
      else $error("two cycle op timing wrong");
   rel_jump_dest_a: assert property (ex && pm_data[15:12] ==
      {1'b1, `CAB_IOP_REL_JUMP} |=> busy ##1 !busy && pm_addr == $past(rel_t, 2))
      else $error("relative jump target or timing wrong");
   abs_jump_dest_a: assert property (ex && rf && op == `CAB_OP_ABS_JUMP
      |=> busy [*2] ##1 !busy && pm_addr == $past(pm_data, 2))
      else $error("absolute jump target or timing wrong");
   abs_call_dest_a: assert property (ex && rf && op == `CAB_OP_ABS_CALL
      |=> busy [*3] ##1 !busy && pm_addr == $past(pm_data, 3))
      else $error("absolute call target or timing wrong");
   exit_four_a: assert property (ex && rf && op >= `CAB_OP_SUB_EXIT
      |=> busy [*3] ##1 !busy)
      else $error("exit did not take four cycles");
   skip_none_a: assert property (ex && rf && op == `CAB_OP_SKIP_IO_LO &&
      io_rdata[pm_data[2:0]] |=> !busy && pm_addr == $past(pm_addr) + 16'h0001)
      else $error("untaken skip not one cycle");
   call_seen_c: cover property (ex && rf && op == `CAB_OP_ABS_CALL);
   exit_seen_c: cover property (ex && rf && op == `CAB_OP_SUB_EXIT);
   io_skip_c: cover property (io_rd && op == `CAB_OP_SKIP_IO_HI);
endmodule // cab_exec_props
bind cab_exec cab_exec_props #(.STACK_DEPTH(STACK_DEPTH), .SP_W(SP_W)) u_props (
   .clk(clk), .arst_n(arst_n), .busy(busy), .pm_addr(pm_addr),
   .pm_data(pm_data), .io_addr(io_addr), .io_rd(io_rd), .io_rdata(io_rdata),
   .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd),
   .sw_rdata(sw_rdata));
`default_nettype wire

// ===== cab_pmem_model.sv
// Purpose: Combinational program store and low I/O registers for the core
// Assumes: Contents are loaded by the bench before reset is released
// Notes:   Only the 32 bit-addressable I/O locations exist here
`timescale 1ns/1ps
`default_nettype none
module cab_pmem_model (
   // Program side
   input wire [15:0] pm_addr,
   output logic [15:0] pm_data,
   // I/O side
   input wire [4:0] io_addr,
   input wire io_rd,
   output logic [7:0] io_rdata
);
////////////////////////////////////////////////////////////////////////////
   logic [15:0] rom [0:31];
   logic [7:0] io_mem [0:31];
   always_comb begin
      pm_data = (pm_addr < 16'h0020) ? rom[pm_addr[4:0]] : 16'h0000;
      // Unselected data flips so a stale value never passes for a read
      io_rdata = io_rd ? io_mem[io_addr] : ~io_mem[io_addr];
   end
endmodule // cab_pmem_model
`default_nettype wire

// ===== cab_exec_tb_top.sv
// Purpose: Runs short programs and checks registers through the soft port
// Assumes: GPR, SREG and PC writes only while parked
// Notes:   Each program ends in a jump to itself, used as a halt
`timescale 1ns/1ps
`default_nettype none
`include "cab_regs.vh"
module cab_exec_tb_top;
   logic clk, arst_n, sw_wr, sw_rd;
   logic [5:0] sw_addr;
   logic [7:0] sw_wdata;
   wire [15:0] pm_addr, pm_data;
   wire [4:0] io_addr;
   wire io_rd, busy;
   wire [7:0] io_rdata, sw_rdata;
   int err_count = 0;
   int samples_checked = 0;
   cab_exec DUT (.clk(clk), .arst_n(arst_n), .pm_addr(pm_addr),
      .pm_data(pm_data), .io_addr(io_addr), .io_rd(io_rd),
      .io_rdata(io_rdata), .sw_addr(sw_addr), .sw_wdata(sw_wdata),
      .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata), .busy(busy));
   cab_pmem_model PM (.pm_addr(pm_addr), .pm_data(pm_data),
      .io_addr(io_addr), .io_rd(io_rd), .io_rdata(io_rdata));
////////////////////////////////////////////////////////////////////////////
   function automatic logic [15:0] rw(logic [4:0] o, logic [4:0] d,
      logic [4:0] r);
      return {1'b0, o, d, r};
   endfunction
   function automatic logic [15:0] iw(logic [2:0] o, logic [11:0] k);
      return {1'b1, o, k};
   endfunction
   task automatic end_of_test;
      $display("checks %0d errors %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      @(posedge clk);
      sw_addr <= a;
      sw_wdata <= d;
      sw_wr <= 1'b1;
      @(posedge clk);
      sw_wr <= 1'b0;
   endtask
   task automatic rd(input logic [5:0] a, input logic [7:0] e);
      @(posedge clk);
      sw_addr <= a;
      sw_rd <= 1'b1;
      @(posedge clk);
      sw_rd <= 1'b0;
      #1;
      samples_checked++;
      if (sw_rdata !== e) begin
         err_count++;
         $display("Error at %0t: read %h expected %h", $time, sw_rdata, e);
      end
   endtask
   // Runs from pc until the halt address shows, then parks the core
   task automatic run_to(input logic [7:0] pc, input logic [15:0] stop);
      int n;
      wr(`CAB_SW_PCL, pc);
      wr(`CAB_SW_PCH, 8'h00);
      wr(`CAB_SW_CTRL, 8'h01);
      n = 0;
      while (pm_addr !== stop && n < 400) begin
         @(posedge clk);
         #1;
         n++;
      end
      wr(`CAB_SW_CTRL, 8'h00);
      n = 0;
      do begin
         @(posedge clk);
         #1;
         n++;
      end while (busy !== 1'b0 && n < 20);
      if (busy !== 1'b0 || pm_addr !== stop) err_count++;
   endtask
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   initial begin
      #100000;
      err_count++;
      end_of_test();
   end
   initial begin
      arst_n = 1'b0;
      sw_wr = 1'b0;
      sw_rd = 1'b0;
      sw_addr = 6'h00;
      sw_wdata = 8'h00;
      for (int i = 0; i < 32; i++) begin
         PM.rom[i] = 16'h0000;
         PM.io_mem[i] = 8'h00;
      end
      PM.io_mem[3] = 8'h01;
      PM.rom[0] = rw(`CAB_OP_SUM_CARRY, 5'd16, 5'd17);
      PM.rom[1] = iw(`CAB_IOP_REL_JUMP, 12'hfff);
      PM.rom[2] = rw(`CAB_OP_INVERT, 5'd2, 5'd0);
      PM.rom[3] = rw(`CAB_OP_PLUS_ONE, 5'd2, 5'd0);
      PM.rom[4] = iw(`CAB_IOP_REL_JUMP, 12'h001);
      PM.rom[5] = iw(`CAB_IOP_ALL_ONES, 12'h000);
      PM.rom[6] = rw(`CAB_OP_CMP_SKIP, 5'd16, 5'd16);
      PM.rom[7] = iw(`CAB_IOP_ALL_ONES, 12'h100);
      PM.rom[8] = rw(`CAB_OP_UPROD, 5'd17, 5'd17);
      PM.rom[9] = rw(`CAB_OP_SKIP_IO_HI, 5'd3, 5'd0);
      PM.rom[10] = rw(`CAB_OP_ABS_CALL, 5'd0, 5'd0);
      PM.rom[12] = rw(`CAB_OP_ABS_JUMP, 5'd0, 5'd0);
      PM.rom[13] = 16'h000f;
      PM.rom[14] = iw(`CAB_IOP_ALL_ONES, 12'h100);
      PM.rom[15] = rw(`CAB_OP_ABS_CALL, 5'd0, 5'd0);
      PM.rom[16] = 16'h0014;
      PM.rom[17] = iw(`CAB_IOP_REL_JUMP, 12'hfff);
      PM.rom[20] = rw(`CAB_OP_SKIP_IO_LO, 5'd3, 5'd0);
      PM.rom[21] = iw(`CAB_IOP_ALL_ONES, 12'h200);
      PM.rom[22] = rw(`CAB_OP_WORD_ADD, 5'd0, 5'd1);
      PM.rom[23] = rw(`CAB_OP_SUB_EXIT, 5'd0, 5'd0);
      repeat (8) @(posedge clk);
      arst_n <= 1'b1;
      rd(`CAB_SW_SREG, `CAB_SREG_RST);
      rd(`CAB_SW_PCL, 8'(`CAB_PC_RST));
      rd(`CAB_SW_CTRL, {7'h00, `CAB_CTRL_RST});
      rd(6'h3f, 8'h00);
      wr(6'd16, 8'h7f);
      wr(6'd17, 8'h01);
      wr(6'd2, 8'hff);
      wr(6'd24, 8'hff);
      wr(6'd25, 8'h00);
      wr(6'd18, 8'h00);
      wr(`CAB_SW_SREG, 8'h01);
      run_to(8'h00, 16'h0001);
      rd(6'd16, 8'h81);
      rd(`CAB_SW_SREG, 8'h2c);
      run_to(8'h02, 16'h0011);
      rd(6'd16, 8'h81);
      rd(6'd17, 8'h01);
      rd(6'd2, 8'h01);
      rd(6'd0, 8'h01);
      rd(6'd1, 8'h00);
      rd(6'd24, 8'h00);
      rd(6'd25, 8'h01);
      rd(6'd18, 8'hff);
      rd(`CAB_SW_SREG, 8'h20);
      rd(`CAB_SW_PCL, 8'h11);
      wr(`CAB_SW_CTRL, 8'h01);
      wr(6'd16, 8'h00);
      wr(`CAB_SW_CTRL, 8'h00);
      rd(6'd16, 8'h81);
      end_of_test();
   end
endmodule // cab_exec_tb_top
`default_nettype wire
